// ==== verilog/css_core_exec.sv ====
// Execution of direct and indirect stores, idle, soft reset and interrupt return.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

module css_core_exec #(
    parameter int APB_AW = 8,
    parameter int PC_W = 15
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB register slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Instruction issue from the decoder.
    input wire logic instr_valid,
    input wire logic [css_pkg::INSTR_W-1:0] instr_word,
    input wire logic [7:0] acc_value,
    input wire logic [css_pkg::BANK_W-1:0] bank_sel,
    input wire logic [PC_W-1:0] top_of_stack,
    output logic instr_ready,
    // Data memory write port.
    output logic mem_we,
    output logic [css_pkg::PTR_W-1:0] mem_addr,
    output logic [7:0] mem_wdata,
    // Program flow and stack.
    output logic pc_advance,
    output logic pc_load,
    output logic [PC_W-1:0] pc_value,
    output logic stack_pop,
    // System control.
    output logic soft_reset_req,
    output logic global_interrupt_enable,
    output logic reset_instruction_flag
);

    // ****************************************
    // Helper functions
    // ****************************************

    // Masked compare of an instruction word against an encoding.
    function automatic logic op_match(input logic [13:0] word, input logic [13:0] mask,
                                      input logic [13:0] val);
        op_match = ((word & mask) == val);
    endfunction

    // ****************************************
    // State and output registers
    // ****************************************
    logic [15:0] ptr0_reg; // File-select pointer 0.
    logic [15:0] ptr0_next;
    logic [15:0] ptr1_reg; // File-select pointer 1.
    logic [15:0] ptr1_next;
    logic ien_reg; // Global interrupt enable.
    logic ien_next;
    logic rif_reg; // Reset instruction flag, low after a soft reset.
    logic rif_next;
    logic [15:0] count_reg; // Count of executed instructions of this block.
    logic [15:0] count_next;
    css_pkg::css_state_e state_reg; // Execution state.
    css_pkg::css_state_e state_next;
    logic ready_reg; // Ready to take an instruction.
    logic ready_next;
    logic mem_we_reg; // One-cycle memory write strobe.
    logic [15:0] mem_addr_reg; // Address of the last store.
    logic [7:0] mem_wdata_reg; // Data of the last store.
    logic pc_adv_reg; // One-cycle program counter advance.
    logic pc_load_reg; // One-cycle program counter load.
    logic [PC_W-1:0] pc_value_reg; // Value for the program counter load.
    logic srst_reg; // One-cycle soft reset request.
    logic pready_reg; // APB ready.
    logic pready_next;
    logic [31:0] prdata_reg; // APB read data.
    logic pslverr_reg; // APB error.

    // ****************************************
    // Instruction decode
    // ****************************************
    logic accept; // Instruction taken this cycle.
    logic dec_direct; // Direct store.
    logic dec_ind; // Indirect store with pointer update mode.
    logic dec_rel; // Indirect store with relative offset.
    logic dec_idle; // Idle instruction.
    logic dec_reset; // Soft reset.
    logic dec_retint; // Return from interrupt.
    logic dec_known; // Any instruction this block executes.
    logic [6:0] file_f; // Direct file operand.
    logic to_port; // Direct store aimed at an indirect data port.
    logic sel_n; // Pointer chosen by the instruction.
    logic [15:0] sel_ptr; // Value of the chosen pointer.
    logic [5:0] rel_ofs; // Offset fed to the pointer calculator.
    logic [15:0] calc_ea; // Effective address from the calculator.
    logic [15:0] calc_new; // Updated pointer from the calculator.
    logic [15:0] direct_addr; // Banked direct address.
    logic [15:0] store_addr; // Address of this store.
    logic do_store; // A store is executed.
    logic do_reset; // A soft reset is executed.
    logic do_retint; // A return from interrupt starts.
    logic ptr_upd; // A moded store steps a pointer.

    assign accept = instr_valid && ready_reg;
    assign dec_direct = op_match(instr_word, css_pkg::DIRECT_MASK, css_pkg::DIRECT_VAL);
    assign dec_ind = op_match(instr_word, css_pkg::IND_MASK, css_pkg::IND_VAL);
    assign dec_rel = op_match(instr_word, css_pkg::REL_MASK, css_pkg::REL_VAL);
    assign dec_idle = (instr_word == css_pkg::OP_IDLE);
    assign dec_reset = (instr_word == css_pkg::OP_SOFT_RESET);
    assign dec_retint = (instr_word == css_pkg::OP_RET_INT);
    assign dec_known = dec_direct || dec_ind || dec_rel || dec_idle || dec_reset || dec_retint;

    // The 7-bit operand covers file registers 0 to 127 of the bank.
    assign file_f = instr_word[css_pkg::FILE_W-1:0];
    assign direct_addr = {3'h0, bank_sel, file_f};

    // The data ports hold nothing, so a direct store to one of them is sent
    // to the address in the matching pointer, which stays unchanged.
    assign to_port = dec_direct && ((file_f == css_pkg::FILE_PORT0)
                                    || (file_f == css_pkg::FILE_PORT1));

    // Operand n picks pointer 0 or 1.
    assign sel_n = dec_direct ? file_f[0]
                 : (dec_rel ? instr_word[css_pkg::REL_N_BIT] : instr_word[css_pkg::IND_N_BIT]);
    assign sel_ptr = sel_n ? ptr1_reg : ptr0_reg;

    // A port access reuses the relative path with a zero offset.
    assign rel_ofs = dec_rel ? instr_word[css_pkg::K_W-1:0] : 6'h00;

    // One calculator serves both pointers; only one is addressed per store.
    css_ptr_calc #(
        .PTR_W(css_pkg::PTR_W),
        .K_W(css_pkg::K_W)
    ) u_calc (
        .ptr(sel_ptr),
        .mode(instr_word[1:0]),
        .rel_form(dec_rel || dec_direct),
        .offset(rel_ofs),
        .eff_addr(calc_ea),
        .ptr_new(calc_new)
    );

    // Plain direct stores use the banked address, all others the pointer path.
    assign store_addr = (dec_direct && !to_port) ? direct_addr : calc_ea;
    assign do_store = accept && (dec_direct || dec_ind || dec_rel);
    assign do_reset = accept && dec_reset;
    assign do_retint = accept && dec_retint;

    // Only the moded form writes a pointer back.
    assign ptr_upd = accept && dec_ind;

    // ****************************************
    // APB decode
    // ****************************************
    logic apb_access; // Access phase in progress.
    logic apb_wr; // Write completes at this edge.
    logic hit_ptr0;
    logic hit_ptr1;
    logic hit_intctl;
    logic hit_pwrctl;
    logic hit_status;
    logic addr_hit; // Address is mapped.
    logic [31:0] rd_mux; // Read data for the addressed register.

    assign apb_access = psel && penable;
    assign apb_wr = apb_access && pready_reg && pwrite;
    assign hit_ptr0 = (paddr == css_pkg::OFS_PTR0);
    assign hit_ptr1 = (paddr == css_pkg::OFS_PTR1);
    assign hit_intctl = (paddr == css_pkg::OFS_INTCTL);
    assign hit_pwrctl = (paddr == css_pkg::OFS_PWRCTL);
    assign hit_status = (paddr == css_pkg::OFS_STATUS);
    assign addr_hit = hit_ptr0 || hit_ptr1 || hit_intctl || hit_pwrctl || hit_status;

    // Ready rises one cycle into the access phase and lasts one cycle, so
    // every transfer takes exactly one wait state.
    assign pready_next = apb_access && !pready_reg;

    // Read multiplexer; unmapped addresses and unused bits read as zero.
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_ptr0)
        begin
            rd_mux[15:0] = ptr0_reg;
        end
        else if (hit_ptr1)
        begin
            rd_mux[15:0] = ptr1_reg;
        end
        else if (hit_intctl)
        begin
            rd_mux[css_pkg::IEN_BIT] = ien_reg;
        end
        else if (hit_pwrctl)
        begin
            rd_mux[css_pkg::RIF_BIT] = rif_reg;
        end
        else if (hit_status)
        begin
            rd_mux[css_pkg::BUSY_BIT] = !ready_reg;
            rd_mux[css_pkg::COUNT_LSB +: 16] = count_reg;
        end
    end

    // ****************************************
    // Next-state logic
    // ****************************************

    // Soft reset returns pointers to their reset value like a hardware
    // reset; an instruction update beats a software write.
    assign ptr0_next = do_reset ? css_pkg::PTR_RST
                     : ((ptr_upd && !sel_n) ? calc_new
                     : ((apb_wr && hit_ptr0) ? pwdata[15:0] : ptr0_reg));
    assign ptr1_next = do_reset ? css_pkg::PTR_RST
                     : ((ptr_upd && sel_n) ? calc_new
                     : ((apb_wr && hit_ptr1) ? pwdata[15:0] : ptr1_reg));

    // The return sets the enable and wins over a software clear in the
    // same cycle, so the event is never lost.
    assign ien_next = do_reset ? css_pkg::IEN_RST
                    : (do_retint ? 1'b1
                    : ((apb_wr && hit_intctl) ? pwdata[css_pkg::IEN_BIT] : ien_reg));

    // The flag survives the soft reset it reports; the instruction clears
    // it and beats a software write in the same cycle.
    assign rif_next = do_reset ? 1'b0
                    : ((apb_wr && hit_pwrctl) ? pwdata[css_pkg::RIF_BIT] : rif_reg);

    // Count of instructions executed here, cleared by the soft reset.
    assign count_next = do_reset ? 16'h0000
                      : ((accept && dec_known) ? count_reg + 16'h0001 : count_reg);

    // The return holds off the next instruction for its second cycle.
    always_comb
    begin
        state_next = css_pkg::CSS_ST_EXEC;
        case (state_reg)
            css_pkg::CSS_ST_EXEC:
            begin
                if (do_retint)
                begin
                    state_next = css_pkg::CSS_ST_RET2;
                end
            end
            css_pkg::CSS_ST_RET2:
            begin
                state_next = css_pkg::CSS_ST_EXEC;
            end
            default:
            begin
                state_next = css_pkg::CSS_ST_EXEC;
            end
        endcase
    end
    assign ready_next = (state_next == css_pkg::CSS_ST_EXEC);

    // ****************************************
    // Architectural registers
    // ****************************************

    // Pointers, enables, flag and counter.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ptr0_reg <= css_pkg::PTR_RST;
            ptr1_reg <= css_pkg::PTR_RST;
            ien_reg <= css_pkg::IEN_RST;
            rif_reg <= css_pkg::RIF_RST;
            count_reg <= 16'h0000;
        end
        else
        begin
            ptr0_reg <= ptr0_next;
            ptr1_reg <= ptr1_next;
            ien_reg <= ien_next;
            rif_reg <= rif_next;
            count_reg <= count_next;
        end
    end

    // Execution state and issue ready.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= css_pkg::CSS_ST_EXEC;
            ready_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            ready_reg <= ready_next;
        end
    end

    // ****************************************
    // Execution outputs
    // ****************************************

    // Store port. The accumulator goes out unchanged and nothing here
    // drives a status flag.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_we_reg <= 1'b0;
            mem_addr_reg <= 16'h0000;
            mem_wdata_reg <= 8'h00;
        end
        else
        begin
            mem_we_reg <= do_store;
            if (do_store)
            begin
                mem_addr_reg <= store_addr;
                mem_wdata_reg <= acc_value;
            end
        end
    end

    // Flow control. Single-cycle instructions other than the soft reset advance the counter, the
    // idle one doing nothing else; the return pops and loads.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pc_adv_reg <= 1'b0;
            pc_load_reg <= 1'b0;
            pc_value_reg <= '0;
            srst_reg <= 1'b0;
        end
        else
        begin
            pc_adv_reg <= accept && dec_known && !dec_retint && !dec_reset;
            pc_load_reg <= do_retint;
            srst_reg <= do_reset;
            if (do_retint)
            begin
                pc_value_reg <= top_of_stack;
            end
        end
    end

    // APB answer registers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= pready_next;
            pslverr_reg <= pready_next && !addr_hit;
            if (pready_next)
            begin
                prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // ****************************************
    // Output assignments
    // ****************************************
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign instr_ready = ready_reg;
    assign mem_we = mem_we_reg;
    assign mem_addr = mem_addr_reg;
    assign mem_wdata = mem_wdata_reg;
    assign pc_advance = pc_adv_reg;
    assign pc_load = pc_load_reg;
    assign pc_value = pc_value_reg;
    assign stack_pop = pc_load_reg; // Pop and load travel together.
    assign soft_reset_req = srst_reg;
    assign global_interrupt_enable = ien_reg;
    assign reset_instruction_flag = rif_reg;

endmodule // css_core_exec

// ==== verilog/css_pkg.sv ====
// Shared constants and types for the core store and return execution block.
package css_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int PTR_W = 16; // File-select pointer and data address width.
    localparam int INSTR_W = 14; // Instruction word width.
    localparam int FILE_W = 7; // Direct file operand width.
    localparam int BANK_W = 6; // Bank select width.
    localparam int K_W = 6; // Signed relative offset width.

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_PTR0 = 8'h00;
    localparam logic [7:0] OFS_PTR1 = 8'h04;
    localparam logic [7:0] OFS_INTCTL = 8'h08;
    localparam logic [7:0] OFS_PWRCTL = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int IEN_BIT = 7; // Global enable in the interrupt control register.
    localparam int RIF_BIT = 0; // Reset instruction flag in the power control register.
    localparam int BUSY_BIT = 0; // Busy bit in the status register.
    localparam int COUNT_LSB = 16; // Executed-instruction count in the status register.
    localparam int IND_N_BIT = 2; // Pointer select of the moded indirect store.
    localparam int REL_N_BIT = 6; // Pointer select of the relative indirect store.

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic IEN_RST = 1'b0;
    localparam logic RIF_RST = 1'b1;

    // ****************************************
    // Instruction encodings
    // ****************************************
    localparam logic [13:0] DIRECT_MASK = 14'h3F80;
    localparam logic [13:0] DIRECT_VAL = 14'h0080;
    localparam logic [13:0] IND_MASK = 14'h3FF8;
    localparam logic [13:0] IND_VAL = 14'h0018;
    localparam logic [13:0] REL_MASK = 14'h3F80;
    localparam logic [13:0] REL_VAL = 14'h3F80;
    localparam logic [13:0] OP_IDLE = 14'h0000;
    localparam logic [13:0] OP_SOFT_RESET = 14'h0001;
    localparam logic [13:0] OP_RET_INT = 14'h0009;

    // Direct file addresses of the two indirect data ports.
    localparam logic [6:0] FILE_PORT0 = 7'h00;
    localparam logic [6:0] FILE_PORT1 = 7'h01;

    // Pointer update modes of the moded indirect store.
    typedef enum logic [1:0] {
        CSS_UM_PREINC = 2'b00,
        CSS_UM_PREDEC = 2'b01,
        CSS_UM_POSTINC = 2'b10,
        CSS_UM_POSTDEC = 2'b11
    } css_um_e;

    // Execution states, one-hot.
    typedef enum logic [1:0] {
        CSS_ST_EXEC = 2'b01,
        CSS_ST_RET2 = 2'b10
    } css_state_e;

endpackage

// ==== verilog/css_ptr_calc.sv ====
// Effective address and next pointer value for one file-select pointer.
`timescale 1ns/1ps

module css_ptr_calc #(
    parameter int PTR_W = 16,
    parameter int K_W = 6
) (
    // Pointer and operation.
    input wire logic [PTR_W-1:0] ptr,
    input wire logic [1:0] mode,
    input wire logic rel_form,
    input wire logic [K_W-1:0] offset,
    // Results.
    output logic [PTR_W-1:0] eff_addr,
    output logic [PTR_W-1:0] ptr_new
);

    // A one at pointer width, so every sum below stays at pointer width.
    localparam logic [PTR_W-1:0] ONE = {{(PTR_W-1){1'b0}}, 1'b1};

    logic [PTR_W-1:0] ptr_inc; // Pointer plus one, wrapping at the top.
    logic [PTR_W-1:0] ptr_dec; // Pointer minus one, wrapping at the bottom.
    logic [PTR_W-1:0] ofs_ext; // Sign-extended relative offset.
    logic [PTR_W-1:0] ptr_rel; // Pointer plus offset.
    logic [PTR_W-1:0] stepped; // Pointer after the step that the mode picks.
    logic step_down; // High for the two decrement modes.
    logic step_first; // High for the two pre modes.

    // Sums are kept at pointer width on purpose: the carry is dropped so the
    // pointer wraps modulo its range, and no status flag is formed.
    assign ptr_inc = ptr + ONE;
    assign ptr_dec = ptr - ONE;
    assign ofs_ext = {{(PTR_W-K_W){offset[K_W-1]}}, offset};
    assign ptr_rel = ptr + ofs_ext;

    // Low mode bit picks decrement, high mode bit picks post.
    assign step_down = (mode == css_pkg::CSS_UM_PREDEC) || (mode == css_pkg::CSS_UM_POSTDEC);
    assign step_first = (mode == css_pkg::CSS_UM_PREINC) || (mode == css_pkg::CSS_UM_PREDEC);
    assign stepped = step_down ? ptr_dec : ptr_inc;

    // Pre modes address the stepped value, post modes the old one.
    // The relative form addresses pointer plus offset and keeps the pointer.
    assign eff_addr = rel_form ? ptr_rel : (step_first ? stepped : ptr);
    assign ptr_new = rel_form ? ptr : stepped;

endmodule // css_ptr_calc

// ==== bench/css_core_exec_sva.sv ====
// Port checker for the core store and return execution block.
`timescale 1ns/1ps

module css_core_exec_sva #(
    parameter int APB_AW = 8,
    parameter int PC_W = 15
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave side.
    input wire logic psel,
    input wire logic penable,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Instruction issue.
    input wire logic instr_valid,
    input wire logic [css_pkg::INSTR_W-1:0] instr_word,
    input wire logic [7:0] acc_value,
    input wire logic [css_pkg::BANK_W-1:0] bank_sel,
    input wire logic [PC_W-1:0] top_of_stack,
    input wire logic instr_ready,
    // Results.
    input wire logic mem_we,
    input wire logic [css_pkg::PTR_W-1:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic pc_advance,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_value,
    input wire logic stack_pop,
    input wire logic soft_reset_req,
    input wire logic global_interrupt_enable,
    input wire logic reset_instruction_flag
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Accepted instruction classes; direct stores to the two ports are excluded.
    wire take = instr_valid && instr_ready;
    wire [6:0] file_sel = instr_word[6:0];
    wire is_dir = (instr_word & css_pkg::DIRECT_MASK) == css_pkg::DIRECT_VAL;
    wire take_dir = take && is_dir && (file_sel[6:1] != 6'h00);
    wire take_ind = take && (((instr_word & css_pkg::IND_MASK) == css_pkg::IND_VAL)
        || ((instr_word & css_pkg::REL_MASK) == css_pkg::REL_VAL));
    wire take_idle = take && (instr_word == css_pkg::OP_IDLE);
    wire take_soft = take && (instr_word == css_pkg::OP_SOFT_RESET);
    wire take_ret = take && (instr_word == css_pkg::OP_RET_INT);
    // Unmapped addresses are the only cause of an error response.
    wire mapped = paddr inside {css_pkg::OFS_PTR0, css_pkg::OFS_PTR1,
        css_pkg::OFS_INTCTL, css_pkg::OFS_PWRCTL, css_pkg::OFS_STATUS};

    apb_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("APB answer not after exactly one wait state");
    err_resp_a: assert property (pready |-> pslverr == !mapped)
        else $error("APB error flag does not match the address map");
    dir_store_a: assert property (take_dir |=> mem_we && pc_advance
        && mem_addr == {3'b000, $past(bank_sel), $past(file_sel)}
        && mem_wdata == $past(acc_value))
        else $error("Direct store address or data wrong");
    ind_store_a: assert property (take_ind |=> mem_we && pc_advance
        && mem_wdata == $past(acc_value))
        else $error("Indirect store did not write the accumulator");
    idle_pc_a: assert property (take_idle |=> pc_advance && !mem_we && !pc_load)
        else $error("Idle instruction did more than advance");
    ret_load_a: assert property (take_ret |=> pc_load
        && pc_value == $past(top_of_stack) && global_interrupt_enable)
        else $error("Interrupt return did not load the return address");
    ret_twocyc_a: assert property (take_ret |=> !instr_ready ##1 instr_ready)
        else $error("Interrupt return not two cycles long");
    pop_pair_a: assert property (stack_pop == pc_load)
        else $error("Stack pop and program load disagree");
    soft_flag_a: assert property (take_soft |=> soft_reset_req
        && !pc_advance && !reset_instruction_flag)
        else $error("Soft reset request or flag wrong");

    cover property (take_ret);
    cover property (take_soft);
    cover property (pready && pslverr);
endmodule // css_core_exec_sva

bind css_core_exec css_core_exec_sva #(.APB_AW(APB_AW), .PC_W(PC_W)) u_sva (.*);

// ==== bench/css_core_exec_tb_top.sv ====
// Self-checking testbench for the core store and return execution block.
`timescale 1ns/1ps

module css_core_exec_tb_top;
    // Stimulus, all but the clock driven by non-blocking assignment just after an edge.
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic instr_valid = 1'b0;
    logic [13:0] instr_word = 14'h0000;
    logic [7:0] acc_value = 8'h00;
    logic [5:0] bank_sel = 6'h00;
    logic [14:0] top_of_stack = 15'h0000;
    // Observed outputs.
    logic [31:0] prdata;
    logic pready, pslverr, instr_ready, mem_we, pc_advance, pc_load, stack_pop;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [14:0] pc_value;
    logic soft_reset_req, global_interrupt_enable, reset_instruction_flag;
    // Scoreboard: expected stores and expected read answers, oldest first.
    logic [32:0] st_q[$];
    logic [32:0] rd_q[$];
    logic [15:0] ptr_m [2] = '{16'h0000, 16'h0000};
    logic [15:0] p, np;
    logic [7:0] pa;
    logic [6:0] f;
    logic [5:0] k, b;
    int n_fail = 0;
    int checks_done = 0;
    integer seed = 32'h484B0D8F;

    always #25 pclk = ~pclk;

    css_core_exec #(.APB_AW(8), .PC_W(15)) uut (.*);

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // One APB transfer; an idle cycle follows so no strobe is set twice in one step.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] exp);
        if (!wr)
            rd_q.push_back(exp);
        instr_valid <= 1'b0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Holds an instruction until accepted; valid stays up for back-to-back issue.
    task automatic issue(input logic [13:0] w, input logic st, input logic [15:0] ea);
        logic [7:0] a;
        a = 8'($random(seed));
        if (st)
            st_q.push_back({9'h000, ea, a});
        instr_valid <= 1'b1;
        instr_word <= w;
        acc_value <= a;
        top_of_stack <= 15'($random(seed));
        @(posedge pclk);
        while (instr_ready !== 1'b1) @(posedge pclk);
    endtask

    // Any store with no note pending pops an empty queue and mismatches.
    always @(posedge pclk)
    begin
        if (presetn && mem_we === 1'b1)
            check({9'h000, mem_addr, mem_wdata}, st_q.pop_front());
        if (presetn && psel && penable && pready === 1'b1 && !pwrite)
            check({pslverr, prdata}, rd_q.pop_front());
    end

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, css_pkg::OFS_PTR1, 0, 33'h0);
        apb(0, css_pkg::OFS_PWRCTL, 0, 33'h1);
        apb(0, 8'h14, 0, 33'h100000000);
        // Every pointer mode on both pointers, first ones at the wrap points.
        for (int i = 0; i < 8; i++)
        begin
            p = (i < 4) ? (i[0] ? 16'h0000 : 16'hFFFF) : 16'($random(seed));
            pa = i[2] ? css_pkg::OFS_PTR1 : css_pkg::OFS_PTR0;
            np = i[0] ? p - 16'h1 : p + 16'h1;
            apb(1, pa, {16'h0, p}, 0);
            issue(css_pkg::IND_VAL | {11'h0, i[2], i[1:0]}, 1, i[1] ? p : np);
            apb(0, pa, 0, {17'h0, np});
            ptr_m[i[2]] = np;
        end
        // Relative offsets at both ends of the range and two random.
        for (int j = 0; j < 4; j++)
        begin
            k = (j == 0) ? 6'h20 : (j == 1) ? 6'h1F : 6'($random(seed));
            p = ptr_m[j[0]];
            issue(css_pkg::REL_VAL | {7'h0, j[0], k}, 1, p + {{10{k[5]}}, k});
            apb(0, j[0] ? css_pkg::OFS_PTR1 : css_pkg::OFS_PTR0, 0, {17'h0, p});
        end
        // Back-to-back direct stores, the two port addresses and the top file.
        for (int j = 0; j < 6; j++)
        begin
            f = (j < 2) ? 7'(j) : (j == 2) ? 7'h7F : 7'($random(seed)) | 7'h04;
            b = 6'($random(seed));
            bank_sel <= b;
            issue(css_pkg::DIRECT_VAL | {7'h0, f}, 1,
                  (j < 2) ? ptr_m[j] : {3'b000, b, f});
        end
        apb(0, css_pkg::OFS_PTR0, 0, {17'h0, ptr_m[0]});
        issue(css_pkg::OP_IDLE, 0, 0);
        issue(css_pkg::OP_RET_INT, 0, 0);
        issue(css_pkg::OP_IDLE, 0, 0);
        apb(0, css_pkg::OFS_INTCTL, 0, 33'h80);
        apb(0, css_pkg::OFS_STATUS, 0, 33'h150000);
        // Soft reset must clear pointer 1, the enable and the reset flag.
        apb(1, css_pkg::OFS_PTR1, 32'h1234, 0);
        issue(css_pkg::OP_SOFT_RESET, 0, 0);
        apb(0, css_pkg::OFS_PWRCTL, 0, 33'h0);
        apb(0, css_pkg::OFS_INTCTL, 0, 33'h0);
        apb(0, css_pkg::OFS_PTR1, 0, 33'h0);
        apb(0, css_pkg::OFS_STATUS, 0, 33'h0);
        // A second hardware reset in mid-run sets the flag again.
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, css_pkg::OFS_PWRCTL, 0, 33'h1);
        check(33'(st_q.size() + rd_q.size()), 33'h0);
        print_verdict();
    end

    // Watchdog: the sequence needs well under a thousand cycles.
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        print_verdict();
    end
endmodule // css_core_exec_tb_top
